// file: core/fsc_map.svh
// Register offsets, field positions, reset values and timing figures
`ifndef FSC_MAP_SVH
`define FSC_MAP_SVH

// Register offsets
`define FSC_ADDR_FAULT_STATUS_SECOND 8'h06
`define FSC_ADDR_DEVICE_CONFIGURATION 8'h07

// Fault status bit positions
`define FSC_BIT_V18_OOR    7
`define FSC_BIT_PAR_ERR    6
`define FSC_BIT_VIN_UVLO   5
`define FSC_BIT_HVINP_UV   4
`define FSC_BIT_TH_SHDN    3
`define FSC_BIT_NV_FLT     2
`define FSC_BIT_VCOM_FLT   1
`define FSC_BIT_TH_WARN    0

// Configuration field positions
`define FSC_BIT_INT_SENSOR 7
`define FSC_BIT_REFRESH    6
`define FSC_TFAULT_HI      1
`define FSC_TFAULT_LO      0

// Reset values
`define FSC_CONFIG_RESET   8'h04
`define FSC_FLAGS_RESET    8'h00

// Timing figures
`define FSC_CLK_KHZ        100000
`define FSC_TFAULT0_MS     15
`define FSC_TFAULT1_MS     30
`define FSC_TFAULT2_MS     60
`define FSC_TFAULT3_MS     90
`define FSC_REFRESH_MS     1000

`endif

// file: core/fsc_pkg.sv
// Types shared by the fault status and configuration logic
package fsc_pkg;

  // Register state of the register bank
  typedef struct packed {
    logic [7:0] cfg;     // Device configuration register
    logic [7:0] flags;   // Second fault status register
    logic [7:0] rdata;   // Read data holding register
    logic       fault_n; // Fault indicator pin, active low
    logic       reload;  // Working register reload pulse
    logic [7:0] sync1;   // First synchroniser stage
    logic [7:0] sync2;   // Second synchroniser stage
  } fsc_state_t;

  // Hold timer state
  typedef struct packed {
    logic [31:0] cnt;    // Cycles spent with run high
    logic        done;   // Limit reached pulse
  } fsc_tmr_t;

endpackage

// file: core/fsc_hold_timer.sv
// Timer that pulses after a level has stayed high for a given count
`timescale 1ns/1ps
`default_nettype none

module fsc_hold_timer
  import fsc_pkg::*;
#(
  parameter int W = 32 // Counter width
) (
  input  wire logic         i_core_clk, // Core clock
  input  wire logic         i_arst_n,   // Asynchronous reset, active low
  input  wire logic         i_run,      // Level that must stay high
  input  wire logic [W-1:0] i_limit,    // Cycles to hold before pulse
  output logic              o_done      // One-cycle pulse, then restarts
);

  fsc_tmr_t st_r; // Registered state
  fsc_tmr_t st_nxt; // Next state

  // Count while running, restart on any drop of the level
  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'b0;
    if (!i_run) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt[W-1:0] >= i_limit - W'(1)) begin
      st_nxt.cnt  = '0;
      st_nxt.done = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 32'h0000_0001;
    end
  end

  // State register
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_done = st_r.done;

endmodule // fsc_hold_timer

`default_nettype wire

// file: core/fsc_regs.sv
// Fault status and configuration register bank of the display supply
//
// Summary of operation
// - Parity error on interface sets flag bit 6
// - Output deviation of 0.25V sets bit 1
// - Buffer in current limit for delay sets bit 1
// - Config bit 7 selects internal temperature sensor
// - Delay field picks 15, 30, 60, 90 ms
// - Mask bit keeps output fault off pin
`timescale 1ns/1ps
`default_nettype none
`include "fsc_map.svh"

module fsc_regs
  import fsc_pkg::*;
#(
  parameter int unsigned P_TFAULT0_CYC = `FSC_TFAULT0_MS * `FSC_CLK_KHZ, // 15 ms
  parameter int unsigned P_TFAULT1_CYC = `FSC_TFAULT1_MS * `FSC_CLK_KHZ, // 30 ms
  parameter int unsigned P_TFAULT2_CYC = `FSC_TFAULT2_MS * `FSC_CLK_KHZ, // 60 ms
  parameter int unsigned P_TFAULT3_CYC = `FSC_TFAULT3_MS * `FSC_CLK_KHZ, // 90 ms
  parameter int unsigned P_REFRESH_CYC = `FSC_REFRESH_MS * `FSC_CLK_KHZ  // 1 s
) (
  input  wire logic       i_core_clk,          // Core clock, 100 MHz
  input  wire logic       i_arst_n,            // Asynchronous reset, active low
  input  wire logic [7:0] i_reg_addr,          // Register address from serial front end
  input  wire logic       i_reg_wr,            // Register write strobe
  input  wire logic       i_reg_rd,            // Register read strobe
  input  wire logic [7:0] i_reg_wdata,         // Register write data
  input  wire logic       i_par_err,           // Parity error pulse from front end
  input  wire logic [7:0] i_fault_mask,        // Per-flag pin masks, 1 = masked
  input  wire logic       i_v18_oor,           // 1.8V rail out of range comparator
  input  wire logic       i_vin_uvlo,          // Input undervoltage comparator
  input  wire logic       i_hvinp_uv,          // Boost output undervoltage comparator
  input  wire logic       i_th_shdn,           // Overtemperature shutdown comparator
  input  wire logic       i_nv_flt,            // Memory transfer fault
  input  wire logic       i_vcom_dev,          // Output 0.25V away from setting
  input  wire logic       i_vcom_ilim,         // Output buffer in current limit
  input  wire logic       i_th_warn,           // Thermal warning comparator
  output logic [7:0]      o_reg_rdata,         // Read data, one cycle after strobe
  output logic [7:0]      o_config,            // Configuration register contents
  output logic            o_int_sensor_sel,    // 1 = internal temperature sensor
  output logic            o_nv_reload,         // Pulse: copy memory to working regs
  output logic            o_fault_indicator_n  // Fault pin, active low
);

  localparam logic [7:0] ILIM = 8'h07; // Sync index of current limit input

  fsc_state_t  st_r;      // Registered state
  fsc_state_t  st_nxt;    // Next state
  logic [31:0] tf_limit;  // Selected fault delay in cycles
  logic        ilim_done; // Current limit held for delay
  logic        ref_tick;  // One second elapsed with refresh on
  logic [7:0]  set_vec;   // Events raising flags this cycle
  logic        rd_status; // Status register read this cycle
  logic [7:0]  raw_pins;  // Asynchronous fault inputs

  // Fault delay decode
  function automatic logic [31:0] tfault_cycles(input logic [1:0] code);
    case (code)
      2'h0:    tfault_cycles = 32'(P_TFAULT0_CYC);
      2'h1:    tfault_cycles = 32'(P_TFAULT1_CYC);
      2'h2:    tfault_cycles = 32'(P_TFAULT2_CYC);
      default: tfault_cycles = 32'(P_TFAULT3_CYC);
    endcase
  endfunction

  assign tf_limit  = tfault_cycles(st_r.cfg[`FSC_TFAULT_HI:`FSC_TFAULT_LO]);
  assign rd_status = i_reg_rd && (i_reg_addr == `FSC_ADDR_FAULT_STATUS_SECOND);
  assign raw_pins  = {i_vcom_ilim, i_v18_oor, i_vin_uvlo, i_hvinp_uv,
                      i_th_shdn, i_nv_flt, i_vcom_dev, i_th_warn};

  // Current limit must persist for the selected delay
  fsc_hold_timer #(
    .W (32)
  ) u_ilim_timer (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_run      (st_r.sync2[ILIM[2:0]]),
    .i_limit    (tf_limit),
    .o_done     (ilim_done)
  );

  // Periodic reload tick while refresh is on
  fsc_hold_timer #(
    .W (32)
  ) u_refresh_timer (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_run      (st_r.cfg[`FSC_BIT_REFRESH]),
    .i_limit    (32'(P_REFRESH_CYC)),
    .o_done     (ref_tick)
  );

  // Events that raise each flag
  always_comb begin
    set_vec                    = '0;
    set_vec[`FSC_BIT_V18_OOR]  = st_r.sync2[6];
    set_vec[`FSC_BIT_PAR_ERR]  = i_par_err;
    set_vec[`FSC_BIT_VIN_UVLO] = st_r.sync2[5];
    set_vec[`FSC_BIT_HVINP_UV] = st_r.sync2[4];
    set_vec[`FSC_BIT_TH_SHDN]  = st_r.sync2[3];
    set_vec[`FSC_BIT_NV_FLT]   = st_r.sync2[2];
    set_vec[`FSC_BIT_VCOM_FLT] = st_r.sync2[1] | ilim_done;
    set_vec[`FSC_BIT_TH_WARN]  = st_r.sync2[0];
  end

  // Next state of the register bank
  always_comb begin
    st_nxt       = st_r;
    // Two-stage synchroniser for comparator inputs
    st_nxt.sync1 = raw_pins;
    st_nxt.sync2 = st_r.sync1;
    // Read clears all flags, a new event in the same cycle wins
    if (rd_status) begin
      st_nxt.flags = set_vec;
    end else begin
      st_nxt.flags = st_r.flags | set_vec;
    end
    // Configuration write
    if (i_reg_wr && (i_reg_addr == `FSC_ADDR_DEVICE_CONFIGURATION)) begin
      st_nxt.cfg = i_reg_wdata;
    end
    // Read data capture, unmapped reads return zero
    if (i_reg_rd) begin
      case (i_reg_addr)
        `FSC_ADDR_FAULT_STATUS_SECOND:  st_nxt.rdata = st_r.flags;
        `FSC_ADDR_DEVICE_CONFIGURATION: st_nxt.rdata = st_r.cfg;
        default:                        st_nxt.rdata = 8'h00;
      endcase
    end
    // Pin follows unmasked flags
    st_nxt.fault_n = ~|(st_r.flags & ~i_fault_mask);
    // Reload only while refresh is enabled
    st_nxt.reload  = ref_tick & st_r.cfg[`FSC_BIT_REFRESH];
  end

  // State register
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r         <= '0;
      st_r.cfg     <= `FSC_CONFIG_RESET;
      st_r.flags   <= `FSC_FLAGS_RESET;
      st_r.fault_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign o_reg_rdata         = st_r.rdata;
  assign o_config            = st_r.cfg;
  assign o_int_sensor_sel    = st_r.cfg[`FSC_BIT_INT_SENSOR];
  assign o_nv_reload         = st_r.reload;
  assign o_fault_indicator_n = st_r.fault_n;

  // Status register read with no new event
  sequence s_quiet_read;
    rd_status && (set_vec == 8'h00);
  endsequence

  // Parity pulse is recorded
  a_par_err_set: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    i_par_err |=> st_r.flags[`FSC_BIT_PAR_ERR])
    else $error("parity error not recorded");

  // Synchronised deviation reaches flag on the next edge
  a_vcom_dev_set: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    st_r.sync2[1] |=> st_r.flags[`FSC_BIT_VCOM_FLT])
    else $error("output deviation not recorded");

  // Held current limit is recorded
  a_ilim_hold_set: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    ilim_done |=> st_r.flags[`FSC_BIT_VCOM_FLT])
    else $error("current limit fault not recorded");

  // Sensor select follows written bit
  a_sensor_sel: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (i_reg_wr && i_reg_addr == `FSC_ADDR_DEVICE_CONFIGURATION)
      |=> o_int_sensor_sel == $past(i_reg_wdata[7]))
    else $error("sensor select does not follow write");

  // Reload only after refresh was on
  a_reload_gate: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    o_nv_reload |-> $past(st_r.cfg[`FSC_BIT_REFRESH], 2))
    else $error("reload without refresh enabled");

  // Fault delay decode
  a_tfault_decode: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (st_r.cfg[1:0] == 2'h0 |-> tf_limit == 32'(P_TFAULT0_CYC)) and
    (st_r.cfg[1:0] == 2'h3 |-> tf_limit == 32'(P_TFAULT3_CYC)))
    else $error("fault delay decode wrong");

  // Masked output fault leaves pin high
  a_mask_pin: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (i_fault_mask[1] && st_r.flags == 8'h02) |=> o_fault_indicator_n)
    else $error("masked fault drove the pin");

  // Unmasked flag pulls the pin low
  a_pin_assert: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    (|(st_r.flags & ~i_fault_mask)) |=> !o_fault_indicator_n)
    else $error("unmasked fault did not drive the pin");

  // Quiet read clears every flag
  a_read_clear: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    s_quiet_read |=> st_r.flags == 8'h00)
    else $error("status read did not clear flags");

  // Flags hold without a read
  a_flag_sticky: assert property (
    @(posedge i_core_clk) disable iff (!i_arst_n)
    !rd_status |=> (st_r.flags & $past(st_r.flags)) == $past(st_r.flags))
    else $error("flag dropped without a read");

endmodule // fsc_regs

`default_nettype wire

// file: test/fsc_host_model.sv
// Host side model that drives the decoded register port of the bank
`timescale 1ns/1ps
`default_nettype none

module fsc_host_model (
  input  wire logic       i_core_clk, // Core clock
  input  wire logic [7:0] i_rdata,    // Read data from the bank
  output logic [7:0]      o_addr,     // Register address
  output logic            o_wr,       // Write strobe
  output logic            o_rd,       // Read strobe
  output logic [7:0]      o_wdata     // Write data
);
  // Idle port at time zero
  initial begin
    o_addr = 8'hFF;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end

  // One write strobe; idle lines then show the inverse, never stale data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_core_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask

  // One read strobe; data taken one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_core_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
  endtask
endmodule // fsc_host_model

`default_nettype wire

// file: test/fault_status_config_regs_test.sv
// Self-checking bench of the fault status and configuration bank
`timescale 1ns/1ps
`default_nettype none

module fault_status_config_regs_test;
  logic       i_core_clk;   // Core clock
  logic       i_arst_n;     // Reset, active low
  logic       par_err;      // Parity error pulse
  logic       vcom_dev;     // Output deviation level
  logic       vcom_ilim;    // Current limit level
  logic [7:0] fault_mask;   // Pin masks
  logic [7:0] addr;         // Register address
  logic       wr_stb;       // Write strobe
  logic       rd_stb;       // Read strobe
  logic [7:0] wdata;        // Write data
  logic [7:0] rdata;        // Read data
  logic [7:0] cfg;          // Config contents
  logic       int_sel;      // Sensor select
  logic       reload;       // Reload pulse
  logic       fault_n;      // Fault pin
  logic [7:0] got;          // Value read back
  logic [5:0] cmp_lvl;      // Remaining comparator levels
  int         cmp_bit [6] = '{0, 2, 3, 4, 5, 7}; // Status bit of each comparator
  int         bad_count;    // Mismatches
  int         tests_run;    // Comparisons
  int         lims [4] = '{20, 40, 80, 120}; // Shortened fault delays

  fsc_regs #(.P_TFAULT0_CYC(20), .P_TFAULT1_CYC(40), .P_TFAULT2_CYC(80),
    .P_TFAULT3_CYC(120), .P_REFRESH_CYC(200)) i_dut (
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_reg_addr(addr),
    .i_reg_wr(wr_stb), .i_reg_rd(rd_stb), .i_reg_wdata(wdata), .i_par_err(par_err),
    .i_fault_mask(fault_mask), .i_v18_oor(cmp_lvl[5]), .i_vin_uvlo(cmp_lvl[4]),
    .i_hvinp_uv(cmp_lvl[3]), .i_th_shdn(cmp_lvl[2]), .i_nv_flt(cmp_lvl[1]),
    .i_vcom_dev(vcom_dev), .i_vcom_ilim(vcom_ilim),
    .i_th_warn(cmp_lvl[0]), .o_reg_rdata(rdata), .o_config(cfg), .o_int_sensor_sel(int_sel),
    .o_nv_reload(reload), .o_fault_indicator_n(fault_n));

  fsc_host_model i_host (.i_core_clk(i_core_clk), .i_rdata(rdata), .o_addr(addr),
    .o_wr(wr_stb), .o_rd(rd_stb), .o_wdata(wdata));

  // Clock of 10 ns period
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  // Compare and count
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Reset values, read-only status and unmapped place
  task automatic t_reset();
    i_host.rd(8'h07, got);
    chk("config", 8'h04, got);
    i_host.wr(8'h06, 8'hFF);
    i_host.rd(8'h06, got);
    chk("status", 8'h00, got);
    i_host.rd(8'h10, got);
    chk("unmapped", 8'h00, got);
    chk("pin", 8'h01, {7'h00, fault_n});
    $display("t_reset done");
  endtask

  // Parity flag, pin, clear on read
  task automatic t_parity();
    @(posedge i_core_clk) par_err <= 1'b1;
    @(posedge i_core_clk) par_err <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    chk("pin", 8'h00, {7'h00, fault_n});
    i_host.rd(8'h06, got);
    chk("status", 8'h40, got);
    i_host.rd(8'h06, got);
    chk("status", 8'h00, got);
    chk("pin", 8'h01, {7'h00, fault_n});
    $display("t_parity done");
  endtask

  // Deviation fault with pin masked
  task automatic t_dev_masked();
    @(posedge i_core_clk) fault_mask <= 8'h02;
    vcom_dev <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    vcom_dev <= 1'b0;
    repeat (5) @(posedge i_core_clk);
    chk("pin", 8'h01, {7'h00, fault_n});
    i_host.rd(8'h06, got);
    chk("status", 8'h02, got);
    @(posedge i_core_clk) fault_mask <= 8'h00;
    $display("t_dev_masked done");
  endtask

  // Current limit against each delay code
  task automatic t_ilim();
    for (int c = 0; c < 4; c++) begin
      i_host.wr(8'h07, 8'h04 | c[7:0]);
      vcom_ilim <= 1'b1;
      repeat (lims[c] - 4) @(posedge i_core_clk);
      vcom_ilim <= 1'b0;
      repeat (4) @(posedge i_core_clk);
      chk("pin", 8'h01, {7'h00, fault_n});
      i_host.rd(8'h06, got);
      chk("short", 8'h00, got);
      @(posedge i_core_clk) vcom_ilim <= 1'b1;
      repeat (lims[c] + 8) @(posedge i_core_clk);
      chk("pin", 8'h00, {7'h00, fault_n});
      vcom_ilim <= 1'b0;
      repeat (4) @(posedge i_core_clk);
      i_host.rd(8'h06, got);
      chk("long", 8'h02, got);
    end
    $display("t_ilim done");
  endtask

  // Sensor select and periodic reload
  task automatic t_config();
    int n;
    i_host.wr(8'h07, 8'h84);
    @(posedge i_core_clk);
    #1;
    chk("sensor", 8'h01, {7'h00, int_sel});
    chk("config", 8'h84, cfg);
    i_host.wr(8'h07, 8'h44);
    n = 0;
    repeat (450) begin
      @(posedge i_core_clk);
      #1;
      if (reload === 1'b1) n++;
    end
    chk("reloads", 8'h02, n[7:0]);
    chk("sensor", 8'h00, {7'h00, int_sel});
    i_host.wr(8'h07, 8'h04);
    n = 0;
    repeat (450) begin
      @(posedge i_core_clk);
      #1;
      if (reload === 1'b1) n++;
    end
    chk("reloads", 8'h00, n[7:0]);
    $display("t_config done");
  endtask

  // Each remaining comparator sets its own flag and drives the pin
  task automatic t_comparators();
    for (int k = 0; k < 6; k++) begin
      @(posedge i_core_clk) cmp_lvl <= 6'h01 << k;
      repeat (2) @(posedge i_core_clk);
      cmp_lvl <= 6'h00;
      repeat (4) @(posedge i_core_clk);
      chk("pin", 8'h00, {7'h00, fault_n});
      i_host.rd(8'h06, got);
      chk("status", 8'h01 << cmp_bit[k], got);
      i_host.rd(8'h06, got);
      chk("cleared", 8'h00, got);
    end
    $display("t_comparators done");
  endtask

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge i_core_clk);
    bad_count++;
    complete_run();
  end

  // Main sequence
  initial begin
    bad_count = 0;
    tests_run = 0;
    i_arst_n = 1'b0;
    par_err = 1'b0;
    vcom_dev = 1'b0;
    vcom_ilim = 1'b0;
    fault_mask = 8'h00;
    cmp_lvl = 6'h00;
    repeat (4) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    t_reset();
    t_parity();
    t_comparators();
    t_dev_masked();
    t_ilim();
    t_config();
    complete_run();
  end
endmodule // fault_status_config_regs_test

`default_nettype wire
